/* bridge_life_ctrl.sv */
// frame lifetime, forwarding decision and address table learning/aging
// assumes rx strobes synchronous to clk, one descriptor per cycle at most
`timescale 1ns/1ps
`default_nettype none

module tx_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] wp_next;
    logic [AW-1:0] rp_reg;
    logic [AW-1:0] rp_next;
    logic [AW:0]   cnt_reg;
    logic [AW:0]   cnt_next;
    logic          push;
    logic          pop;

    always_comb begin
        in_ready  = (cnt_reg != (AW+1)'(DEPTH));
        out_valid = (cnt_reg != '0);
        out_data  = mem_reg[rp_reg];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wp_next   = wp_reg;
        rp_next   = rp_reg;
        if (push) begin
            wp_next = (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
        end
        if (pop) begin
            rp_next = (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
        end
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wp_reg] <= in_data;
        end
    end

endmodule : tx_fifo

module bridge_life_ctrl #(
    parameter int ENTRIES = 16,
    parameter int MS_CYC  = bridge_life_pkg::MS_CYCLES,
    parameter int QDEPTH  = 8
) (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [31:0]                     reg_rdata,
    input  wire logic                       rx_start,
    input  wire logic [bridge_life_pkg::PORT_W-1:0] rx_start_port,
    input  wire logic                       rx_valid,
    input  wire bridge_life_pkg::rx_desc_t  rx_desc,
    input  wire logic                       topo_change,
    output logic                            ctl_valid,
    output bridge_life_pkg::rx_desc_t       ctl_desc,
    output logic                            tx_valid,
    input  wire logic                       tx_ready,
    output bridge_life_pkg::tx_desc_t       tx_desc,
    output bridge_life_pkg::port_phase_t    port_phase
);
    localparam int IW = $clog2(ENTRIES);
    localparam int TXW = $bits(bridge_life_pkg::tx_desc_t);
    localparam int NP = bridge_life_pkg::NPORT;
    localparam int SW = bridge_life_pkg::STAMP_W;

    // time base
    logic [31:0]   ms_cnt_reg;
    logic [31:0]   ms_cnt_next;
    logic [9:0]    sub_reg;
    logic [9:0]    sub_next;
    logic [SW-1:0] now_ms_reg;
    logic [SW-1:0] now_ms_next;
    logic [SW-1:0] cyc_reg;
    logic [SW-1:0] cyc_next;
    logic [7:0]    boot_s_reg;
    logic [7:0]    boot_s_next;
    logic          ms_tick;
    logic          sec_tick;
    bridge_life_pkg::port_phase_t phase_next;

    // configuration and status
    logic [7:0]    fwd_delay_reg;
    logic [7:0]    fwd_delay_next;
    logic [15:0]   age_norm_reg;
    logic [15:0]   age_norm_next;
    logic [15:0]   age_short_reg;
    logic [15:0]   age_short_next;
    logic [16:0]   proto_reg;
    logic [16:0]   proto_next;
    logic [31:0]   drop_life_reg;
    logic [31:0]   drop_life_next;
    logic [31:0]   drop_full_reg;
    logic [31:0]   drop_full_next;
    logic [SW-1:0] latency_reg;
    logic [SW-1:0] latency_next;
    logic [SW-1:0] resid_reg;
    logic [SW-1:0] resid_next;
    logic [31:0]   rdata_next;

    // address table
    logic [47:0]   fdb_mac_reg  [ENTRIES];
    logic [47:0]   fdb_mac_next [ENTRIES];
    logic [1:0]    fdb_port_reg [ENTRIES];
    logic [1:0]    fdb_port_next[ENTRIES];
    logic [15:0]   fdb_age_reg  [ENTRIES];
    logic [15:0]   fdb_age_next [ENTRIES];
    logic [ENTRIES-1:0] fdb_vld_reg;
    logic [ENTRIES-1:0] fdb_vld_next;
    logic [SW-1:0] start_reg  [NP];
    logic [SW-1:0] start_next [NP];

    // data path
    logic          ctl_valid_next;
    bridge_life_pkg::rx_desc_t ctl_desc_next;
    logic          sa_hit;
    logic [IW-1:0] sa_idx;
    logic          da_hit;
    logic [IW-1:0] da_idx;
    logic          free_ok;
    logic [IW-1:0] free_idx;
    logic          learn_en;
    logic          table_full;
    logic [15:0]   age_lim;
    logic [NP-1:0] dst_mask;
    logic          proto_block;
    logic          enq;
    logic          q_in_ready;
    logic          q_out_valid;
    logic          q_out_ready;
    logic          stale;
    logic [SW-1:0] head_age;
    logic [IW:0]   fdb_cnt;
    bridge_life_pkg::tx_desc_t q_in;
    bridge_life_pkg::tx_desc_t q_head;

    function automatic logic [IW:0] lookup(input logic [47:0] mac);
        logic [IW:0] r;
        r = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (fdb_vld_reg[i] && fdb_mac_reg[i] == mac) begin
                r = {1'b1, IW'(i)};
            end
        end
        return r;
    endfunction : lookup

    // time base and start-up phase
    always_comb begin
        ms_tick     = (ms_cnt_reg == 32'(MS_CYC - 1));
        ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + 32'h1;
        sec_tick    = ms_tick &&
                      (sub_reg == 10'(bridge_life_pkg::MS_PER_S - 1));
        sub_next    = sub_reg;
        if (ms_tick) begin
            sub_next = sec_tick ? '0 : sub_reg + 10'h1;
        end
        now_ms_next = now_ms_reg + SW'(ms_tick);
        cyc_next    = cyc_reg + 16'h1;
        boot_s_next = boot_s_reg;
        if (sec_tick && port_phase != bridge_life_pkg::PH_FWD) begin
            boot_s_next = boot_s_reg + 8'h1;
        end
        // wait the full delay, learning in its second half
        if (port_phase == bridge_life_pkg::PH_FWD) begin
            phase_next = bridge_life_pkg::PH_FWD;
        end else if (boot_s_reg >= fwd_delay_reg) begin
            phase_next = bridge_life_pkg::PH_FWD;
        end else if (boot_s_reg >= (fwd_delay_reg >> 1)) begin
            phase_next = bridge_life_pkg::PH_LEARN;
        end else begin
            phase_next = bridge_life_pkg::PH_WAIT;
        end
        for (int p = 0; p < NP; p++) begin
            start_next[p] = start_reg[p];
        end
        if (rx_start) begin
            start_next[rx_start_port] = now_ms_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ms_cnt_reg <= '0;
            sub_reg    <= '0;
            now_ms_reg <= '0;
            cyc_reg    <= '0;
            boot_s_reg <= '0;
            port_phase <= bridge_life_pkg::PH_WAIT;
            for (int p = 0; p < NP; p++) begin
                start_reg[p] <= '0;
            end
        end else begin
            ms_cnt_reg <= ms_cnt_next;
            sub_reg    <= sub_next;
            now_ms_reg <= now_ms_next;
            cyc_reg    <= cyc_next;
            boot_s_reg <= boot_s_next;
            port_phase <= phase_next;
            for (int p = 0; p < NP; p++) begin
                start_reg[p] <= start_next[p];
            end
        end
    end

    // address table: aging, learning, lookup
    always_comb begin
        {sa_hit, sa_idx} = lookup(rx_desc.sa);
        {da_hit, da_idx} = lookup(rx_desc.da);
        free_ok  = 1'b0;
        free_idx = '0;
        fdb_cnt  = '0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (!fdb_vld_reg[i]) begin
                free_ok  = 1'b1;
                free_idx = IW'(i);
            end
            fdb_cnt = fdb_cnt + (IW+1)'(fdb_vld_reg[i]);
        end
        table_full = !free_ok;
        learn_en   = (port_phase != bridge_life_pkg::PH_WAIT);
        age_lim    = topo_change ? age_short_reg : age_norm_reg;
        fdb_vld_next = fdb_vld_reg;
        for (int i = 0; i < ENTRIES; i++) begin
            fdb_mac_next[i]  = fdb_mac_reg[i];
            fdb_port_next[i] = fdb_port_reg[i];
            fdb_age_next[i]  = fdb_age_reg[i];
            if (sec_tick && fdb_vld_reg[i]) begin
                if (fdb_age_reg[i] + 16'h1 >= age_lim) begin
                    fdb_vld_next[i] = 1'b0;
                end else begin
                    fdb_age_next[i] = fdb_age_reg[i] + 16'h1;
                end
            end
        end
        // learning runs beside every other activity outside PH_WAIT, never deferred
        if (rx_valid && learn_en) begin
            if (sa_hit) begin
                fdb_port_next[sa_idx] = rx_desc.port;
                fdb_age_next[sa_idx]  = '0;
                fdb_vld_next[sa_idx]  = 1'b1;
            end else if (free_ok) begin
                fdb_mac_next[free_idx]  = rx_desc.sa;
                fdb_port_next[free_idx] = rx_desc.port;
                fdb_age_next[free_idx]  = '0;
                fdb_vld_next[free_idx]  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            fdb_vld_reg <= '0;
            for (int i = 0; i < ENTRIES; i++) begin
                fdb_mac_reg[i]  <= '0;
                fdb_port_reg[i] <= '0;
                fdb_age_reg[i]  <= '0;
            end
        end else begin
            fdb_vld_reg <= fdb_vld_next;
            for (int i = 0; i < ENTRIES; i++) begin
                fdb_mac_reg[i]  <= fdb_mac_next[i];
                fdb_port_reg[i] <= fdb_port_next[i];
                fdb_age_reg[i]  <= fdb_age_next[i];
            end
        end
    end

    // forwarding decision, control bypass and transmit queue head
    always_comb begin
        if (da_hit) begin
            dst_mask = NP'(1) << fdb_port_reg[da_idx];
        end else begin
            dst_mask = '1;
        end
        dst_mask    = dst_mask & ~(NP'(1) << rx_desc.port);
        proto_block = proto_reg[bridge_life_pkg::PROTO_EN_BIT] &&
                      (rx_desc.proto == proto_reg[15:0]);
        enq = rx_valid && (rx_desc.cls == bridge_life_pkg::CLS_DATA) &&
              (port_phase == bridge_life_pkg::PH_FWD) &&
              !proto_block && (dst_mask != '0);
        q_in.dst_mask = dst_mask;
        q_in.handle   = rx_desc.handle;
        q_in.rx_stamp = start_reg[rx_desc.port];
        q_in.end_cyc  = cyc_reg;
        q_in.quick    = !q_out_valid;
        ctl_valid_next = rx_valid &&
                         (rx_desc.cls != bridge_life_pkg::CLS_DATA);
        ctl_desc_next  = rx_valid ? rx_desc : ctl_desc;
        head_age = now_ms_reg - q_head.rx_stamp;
        stale    = q_out_valid &&
                   (head_age > SW'(bridge_life_pkg::MAX_LIFE_MS));
        tx_valid    = q_out_valid && !stale;
        tx_desc     = q_head;
        q_out_ready = stale || tx_ready;
    end

    tx_fifo #(
        .W     (TXW),
        .DEPTH (QDEPTH)
    ) u_txq (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (enq),
        .in_ready  (q_in_ready),
        .in_data   (q_in),
        .out_valid (q_out_valid),
        .out_ready (q_out_ready),
        .out_data  (q_head)
    );

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctl_valid <= 1'b0;
            ctl_desc  <= '0;
        end else begin
            ctl_valid <= ctl_valid_next;
            ctl_desc  <= ctl_desc_next;
        end
    end

    // register port and statistics
    always_comb begin
        fwd_delay_next = fwd_delay_reg;
        age_norm_next  = age_norm_reg;
        age_short_next = age_short_reg;
        proto_next     = proto_reg;
        drop_life_next = drop_life_reg + 32'(stale);
        drop_full_next = drop_full_reg + 32'(enq && !q_in_ready);
        latency_next   = latency_reg;
        resid_next     = resid_reg;
        if (tx_valid && tx_ready) begin
            resid_next = head_age;
            if (q_head.quick) begin
                latency_next = cyc_reg - q_head.end_cyc;
            end
        end
        if (reg_wr) begin
            case (reg_addr)
                bridge_life_pkg::OFS_FWD_DELAY: begin
                    fwd_delay_next = reg_wdata[7:0];
                end
                bridge_life_pkg::OFS_AGE_NORM: begin
                    age_norm_next = reg_wdata[15:0];
                end
                bridge_life_pkg::OFS_AGE_SHORT: begin
                    age_short_next = reg_wdata[15:0];
                end
                bridge_life_pkg::OFS_PROTO: begin
                    proto_next = reg_wdata[16:0];
                end
                default: begin
                end
            endcase
        end
        rdata_next = '0;
        if (reg_rd) begin
            case (reg_addr)
                bridge_life_pkg::OFS_FWD_DELAY: begin
                    rdata_next = {24'h0, fwd_delay_reg};
                end
                bridge_life_pkg::OFS_AGE_NORM: begin
                    rdata_next = {16'h0, age_norm_reg};
                end
                bridge_life_pkg::OFS_AGE_SHORT: begin
                    rdata_next = {16'h0, age_short_reg};
                end
                bridge_life_pkg::OFS_PROTO: begin
                    rdata_next = {15'h0, proto_reg};
                end
                bridge_life_pkg::OFS_STATUS: begin
                    rdata_next[1:0] = port_phase;
                    rdata_next[bridge_life_pkg::STAT_FULL_BIT] = table_full;
                    rdata_next[bridge_life_pkg::STAT_CNT_LSB +: IW+1] = fdb_cnt;
                end
                bridge_life_pkg::OFS_DROP_LIFE: begin
                    rdata_next = drop_life_reg;
                end
                bridge_life_pkg::OFS_DROP_FULL: begin
                    rdata_next = drop_full_reg;
                end
                bridge_life_pkg::OFS_LATENCY: begin
                    rdata_next = {16'h0, latency_reg};
                end
                bridge_life_pkg::OFS_RESIDENCE: begin
                    rdata_next = {16'h0, resid_reg};
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            fwd_delay_reg <= bridge_life_pkg::FWD_DELAY_RST;
            age_norm_reg  <= bridge_life_pkg::AGE_NORM_RST;
            age_short_reg <= bridge_life_pkg::AGE_SHORT_RST;
            proto_reg     <= '0;
            drop_life_reg <= '0;
            drop_full_reg <= '0;
            latency_reg   <= '0;
            resid_reg     <= '0;
            reg_rdata     <= '0;
        end else begin
            fwd_delay_reg <= fwd_delay_next;
            age_norm_reg  <= age_norm_next;
            age_short_reg <= age_short_next;
            proto_reg     <= proto_next;
            drop_life_reg <= drop_life_next;
            drop_full_reg <= drop_full_next;
            latency_reg   <= latency_next;
            resid_reg     <= resid_next;
            reg_rdata     <= rdata_next;
        end
    end

endmodule : bridge_life_ctrl

`default_nettype wire

/* bridge_life_ctrl_asserts.sv */
// assertions on the ports of bridge_life_ctrl
// assumes clk rising edge and nrst synchronous active low
`timescale 1ns/1ps
`default_nettype none
module bridge_life_chk (
    input wire logic                         clk,
    input wire logic                         nrst,
    input wire logic                         reg_rd,
    input wire logic [31:0]                  reg_rdata,
    input wire logic                         rx_valid,
    input wire bridge_life_pkg::rx_desc_t    rx_desc,
    input wire logic                         ctl_valid,
    input wire bridge_life_pkg::rx_desc_t    ctl_desc,
    input wire logic                         tx_valid,
    input wire bridge_life_pkg::tx_desc_t    tx_desc,
    input wire bridge_life_pkg::port_phase_t port_phase
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_rdz;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rdz: assert property (p_rdz) else $error("stray read data");
    property p_ctl;
        rx_valid && rx_desc.cls != bridge_life_pkg::CLS_DATA |=> ctl_valid;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control frame lost");
    property p_noctl;
        !(rx_valid && rx_desc.cls != bridge_life_pkg::CLS_DATA) |=> !ctl_valid;
    endproperty
    a_noctl: assert property (p_noctl) else $error("stray ctl pulse");
    property p_copy;
        rx_valid |=> ctl_desc == $past(rx_desc);
    endproperty
    a_copy: assert property (p_copy) else $error("ctl desc wrong");
    property p_boot;
        $rose(nrst) |-> port_phase == bridge_life_pkg::PH_WAIT;
    endproperty
    a_boot: assert property (p_boot) else $error("phase after reset");
    property p_hold;
        port_phase != bridge_life_pkg::PH_FWD |-> !tx_valid;
    endproperty
    a_hold: assert property (p_hold) else $error("tx before forward");
    property p_mask;
        tx_valid |-> tx_desc.dst_mask != 4'h0;
    endproperty
    a_mask: assert property (p_mask) else $error("empty dest mask");
    property p_learn;
        $past(port_phase) == bridge_life_pkg::PH_WAIT |->
            port_phase != bridge_life_pkg::PH_FWD;
    endproperty
    a_learn: assert property (p_learn) else $error("learn skipped");
endmodule : bridge_life_chk
bind bridge_life_ctrl bridge_life_chk i_chk (
    .clk, .nrst, .reg_rd, .reg_rdata, .rx_valid, .rx_desc, .ctl_valid,
    .ctl_desc, .tx_valid, .tx_desc, .port_phase
);
`default_nettype wire

/* bridge_life_pkg.sv */
// constants and carrier types for the frame lifetime and address table block
// assumes a 40 MHz clock and a plain strobe register port
package bridge_life_pkg;

    localparam int NPORT   = 4;
    localparam int PORT_W  = 2;
    localparam int MAC_W   = 48;
    localparam int STAMP_W = 16;
    localparam int HND_W   = 8;
    localparam int PROTO_W = 16;

    // time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PER_S      = 1000;

    // residence limits
    localparam int MIN_LIFE_S  = 1;
    localparam int MAX_LIFE_S  = 2;
    localparam int MIN_LIFE_MS = MIN_LIFE_S * MS_PER_S;
    localparam int MAX_LIFE_MS = MAX_LIFE_S * MS_PER_S;

    // register offsets
    localparam logic [7:0] OFS_FWD_DELAY = 8'h00;
    localparam logic [7:0] OFS_AGE_NORM  = 8'h04;
    localparam logic [7:0] OFS_AGE_SHORT = 8'h08;
    localparam logic [7:0] OFS_PROTO     = 8'h0C;
    localparam logic [7:0] OFS_STATUS    = 8'h10;
    localparam logic [7:0] OFS_DROP_LIFE = 8'h14;
    localparam logic [7:0] OFS_DROP_FULL = 8'h18;
    localparam logic [7:0] OFS_LATENCY   = 8'h1C;
    localparam logic [7:0] OFS_RESIDENCE = 8'h20;

    // field positions and reset values
    localparam int PROTO_EN_BIT = 16;
    localparam int STAT_FULL_BIT = 2;
    localparam int STAT_CNT_LSB  = 8;
    localparam logic [7:0]  FWD_DELAY_RST = 8'h0F;
    localparam logic [15:0] AGE_NORM_RST  = 16'h012C;
    localparam logic [15:0] AGE_SHORT_RST = 16'h000F;

    typedef enum logic [1:0] {
        CLS_DATA,
        CLS_MGMT,
        CLS_STP
    } frame_cls_t;

    typedef enum logic [1:0] {
        PH_WAIT,
        PH_LEARN,
        PH_FWD
    } port_phase_t;

    typedef struct packed {
        logic [MAC_W-1:0]   sa;
        logic [MAC_W-1:0]   da;
        logic [PROTO_W-1:0] proto;
        frame_cls_t         cls;
        logic [PORT_W-1:0]  port;
        logic [HND_W-1:0]   handle;
    } rx_desc_t;

    typedef struct packed {
        logic [NPORT-1:0]   dst_mask;
        logic [HND_W-1:0]   handle;
        logic [STAMP_W-1:0] rx_stamp;
        logic [STAMP_W-1:0] end_cyc;
        logic               quick;
    } tx_desc_t;

endpackage : bridge_life_pkg

/* tb.sv */
// bench for bridge_life_ctrl: registers, frames, lifetime, queue, aging
// tx side is tx_sink; time scaled by MS_CYC = 2
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                         clk = 1'b0;
    logic                         nrst = 1'b0;
    logic                         reg_wr = 1'b0;
    logic                         reg_rd = 1'b0;
    logic [7:0]                   reg_addr = 8'h00;
    logic [31:0]                  reg_wdata = 32'h0;
    logic                         rx_start = 1'b0;
    logic                         rx_valid = 1'b0;
    logic [1:0]                   rx_port = 2'h0;
    bridge_life_pkg::rx_desc_t    rx_desc = '0;
    logic                         topo = 1'b0;
    logic                         stall = 1'b0;
    logic                         ctl_valid, tx_valid, tx_ready;
    bridge_life_pkg::tx_desc_t    tx_desc;
    bridge_life_pkg::port_phase_t phase;
    logic [31:0]                  reg_rdata, d;
    logic [7:0]                   taken;
    logic [3:0]                   mask;
    int                           mismatches = 0;
    int                           cmp_count = 0;
    int                           k;
    bridge_life_ctrl #(.ENTRIES(6), .MS_CYC(2)) i_dut (
        .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .rx_start, .rx_start_port(rx_port), .rx_valid, .rx_desc,
        .topo_change(topo), .ctl_valid, .ctl_desc(), .tx_valid, .tx_ready,
        .tx_desc, .port_phase(phase));
    tx_sink i_sink (.clk, .nrst, .stall, .tx_valid, .tx_desc, .tx_ready,
        .taken, .last_mask(mask));
    initial forever #12.5 clk = ~clk;
    task automatic finish_test;
        if (mismatches == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rdchk(input logic [7:0] a, input logic [31:0] v);
        rd(a);
        chk(d, v);
    endtask : rdchk
    task automatic send(input logic [1:0] p, input logic [47:0] sa,
            input logic [47:0] da, input bridge_life_pkg::frame_cls_t c);
        @(posedge clk);
        rx_start <= 1'b1;
        rx_port  <= p;
        @(posedge clk);
        rx_start <= 1'b0;
        rx_valid <= 1'b1;
        rx_desc  <= '{sa, da, 16'h0800, c, p, 8'h5A};
        @(posedge clk);
        rx_valid <= 1'b0;
        #1;
    endtask : send
    task automatic wtk(input logic [7:0] n);
        int i;
        for (i = 0; i < 100 && taken !== n; i++)
            @(posedge clk) #1;
        chk({24'h0, taken}, {24'h0, n});
        if (i == 100) finish_test();
    endtask : wtk
    task automatic wph(input logic [1:0] ph);
        int i;
        for (i = 0; i < 3000 && d[1:0] !== ph; i++)
            rd(bridge_life_pkg::OFS_STATUS);
        chk({30'h0, d[1:0]}, {30'h0, ph});
        if (i == 3000) finish_test();
    endtask : wph
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rdchk(bridge_life_pkg::OFS_FWD_DELAY, 32'h0000000F);
        rdchk(bridge_life_pkg::OFS_AGE_NORM, 32'h0000012C);
        rdchk(8'h40, 32'h0);
        wr(bridge_life_pkg::OFS_FWD_DELAY, 32'h2);
        wr(bridge_life_pkg::OFS_AGE_NORM, 32'h64);
        wr(bridge_life_pkg::OFS_AGE_SHORT, 32'h1);
        rdchk(bridge_life_pkg::OFS_AGE_SHORT, 32'h1);
        send(2'h0, 48'hA, 48'h99, bridge_life_pkg::CLS_MGMT);
        chk({31'h0, ctl_valid}, 32'h1);
        send(2'h1, 48'hB, 48'h99, bridge_life_pkg::CLS_STP);
        chk({31'h0, ctl_valid}, 32'h1);
        send(2'h0, 48'hA, 48'h99, bridge_life_pkg::CLS_DATA);
        chk({31'h0, ctl_valid}, 32'h0);
        rdchk(bridge_life_pkg::OFS_STATUS, 32'h0);
        wph(2'h1);
        send(2'h0, 48'hA, 48'h99, bridge_life_pkg::CLS_DATA);
        rdchk(bridge_life_pkg::OFS_STATUS, 32'h101);
        wph(2'h2);
        chk({24'h0, taken}, 32'h0);
        send(2'h1, 48'hB, 48'hA, bridge_life_pkg::CLS_DATA);
        wtk(8'h1);
        chk({28'h0, mask}, 32'h1);
        rdchk(bridge_life_pkg::OFS_LATENCY, 32'h1);
        send(2'h2, 48'hC, 48'h99, bridge_life_pkg::CLS_DATA);
        wtk(8'h2);
        chk({28'h0, mask}, 32'hB);
        send(2'h1, 48'hD, 48'hB, bridge_life_pkg::CLS_DATA);
        wr(bridge_life_pkg::OFS_PROTO, 32'h00010800);
        send(2'h2, 48'hC, 48'hA, bridge_life_pkg::CLS_DATA);
        wr(bridge_life_pkg::OFS_PROTO, 32'h0);
        chk({24'h0, taken}, 32'h2);
        stall <= 1'b1;
        send(2'h3, 48'h2D, 48'hA, bridge_life_pkg::CLS_DATA);
        repeat (3700) @(posedge clk);
        #1 chk({31'h0, tx_valid}, 32'h1);
        for (k = 0; k < 600 && tx_valid === 1'b1; k++)
            @(posedge clk) #1;
        chk({31'h0, tx_valid}, 32'h0);
        if (k == 600) finish_test();
        rdchk(bridge_life_pkg::OFS_DROP_LIFE, 32'h1);
        repeat (9) send(2'h3, 48'hE, 48'h99, bridge_life_pkg::CLS_DATA);
        rdchk(bridge_life_pkg::OFS_DROP_FULL, 32'h1);
        @(posedge clk) stall <= 1'b0;
        wtk(8'hA);
        chk({28'h0, mask}, 32'h7);
        rdchk(bridge_life_pkg::OFS_STATUS, 32'h606);
        send(2'h0, 48'hF, 48'hF, bridge_life_pkg::CLS_DATA);
        wtk(8'hB);
        chk({28'h0, mask}, 32'hE);
        @(posedge clk) topo <= 1'b1;
        repeat (6000) @(posedge clk);
        rdchk(bridge_life_pkg::OFS_STATUS, 32'h2);
        finish_test();
    end
endmodule : tb
`default_nettype wire

/* tx_sink.sv */
// transmit side model: takes queue heads, stalls on command
// same clock as bridge_life_ctrl
`timescale 1ns/1ps
`default_nettype none
module tx_sink (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      stall,
    input  wire logic                      tx_valid,
    input  wire bridge_life_pkg::tx_desc_t tx_desc,
    output logic                           tx_ready,
    output logic [7:0]                     taken,
    output logic [3:0]                     last_mask
);
    // a stall stands for a busy outbound lan
    assign tx_ready = !stall;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            taken     <= 8'h00;
            last_mask <= 4'h0;
        end else if (tx_valid && tx_ready) begin
            taken     <= taken + 8'h01;
            last_mask <= tx_desc.dst_mask;
        end
    end
endmodule : tx_sink
`default_nettype wire
